// ---- pps_far_side.sv ----
// Far-side model: strap resistors, MAC and management clock
module pps_far_side (
    // Clock
    input wire logic pclk,
    // Resistor levels {style, clken, mode[3:0], addr[2:0]}
    input wire logic [8:0] pulls,
    // Device drives on shared pins
    input wire logic link_indicator_out,
    input wire logic link_indicator_oe,
    input wire logic activity_indicator_out,
    input wire logic activity_indicator_oe,
    input wire logic [3:0] rx_data_out,
    input wire logic rx_ctl_out,
    input wire logic rx_clk_out,
    input wire logic rx_oe,
    input wire logic refclk_out_pin,
    input wire logic refclk_oe,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    // Pin levels seen by the device
    output logic link_indicator_in,
    output logic activity_indicator_in,
    output logic [3:0] rx_data_in,
    output logic rx_ctl_in,
    output logic rx_clk_in,
    output logic refclk_in,
    output logic mdio_in,
    // MAC transmit and management clock
    output logic [3:0] tx_data_in,
    output logic tx_ctl_in,
    output logic tx_clk_in,
    output logic mdc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] cnt_q = 6'h00;
    // A released pin falls back to its resistor
    assign link_indicator_in = link_indicator_oe ? link_indicator_out : pulls[1];
    assign activity_indicator_in = activity_indicator_oe ? activity_indicator_out : pulls[0];
    assign rx_clk_in = rx_oe ? rx_clk_out : pulls[2];
    assign rx_data_in = rx_oe ? rx_data_out : pulls[6:3];
    assign rx_ctl_in = rx_oe ? rx_ctl_out : pulls[7];
    assign refclk_in = refclk_oe ? refclk_out_pin : pulls[8];
    // Management data line has a pull-up
    assign mdio_in = mdio_oe ? mdio_out : 1'b1;
    always @(posedge pclk) begin
        cnt_q <= cnt_q + 6'h01;
    end
    // Moving pattern so a stuck path shows
    assign tx_data_in = cnt_q[4:1];
    assign tx_ctl_in = cnt_q[5];
    assign tx_clk_in = cnt_q[0];
    assign mdc = cnt_q[2];
endmodule // pps_far_side

// ---- pps_led_enc.sv ----
// Indicator encoder for single and tri-color LED styles
module pps_led_enc (
    input wire logic pclk,
    input wire logic presetn,
    pps_led_if.enc led
);
    import pps_pkg::*;
    logic link_d;
    logic act_d;
    logic link_q;
    logic act_q;

    always_comb begin
        link_d = 1'b1;
        act_d = 1'b1;
        if (led.single_mode) begin
            link_d = ~led.link_up; // RULE3
            act_d = led.activity ? led.blink : 1'b1; // RULE3
        end else if (led.link_up) begin
            case (led.speed) // RULE4 RULE5
                PPS_SPD_1000: link_d = led.activity ? led.blink : 1'b0;
                PPS_SPD_100: act_d = led.activity ? led.blink : 1'b0;
                PPS_SPD_10: begin
                    link_d = led.activity ? led.blink : 1'b0;
                    act_d = led.activity ? led.blink : 1'b0;
                end
                default: begin
                    link_d = 1'b1;
                    act_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_q <= 1'b1;
            act_q <= 1'b1;
        end else begin
            link_q <= link_d;
            act_q <= act_d;
        end
    end

    assign led.link_ind = link_q;
    assign led.act_ind = act_q;

    property p_single_link;
        @(posedge pclk) disable iff (!presetn)
        led.single_mode && $stable(led.single_mode) |=> link_q == ~$past(led.link_up);
    endproperty
    a_single_link: assert property (p_single_link) else $error("link indicator wrong"); // RULE3

    property p_tri_none;
        @(posedge pclk) disable iff (!presetn)
        !led.single_mode && !led.link_up |=> link_q && act_q;
    endproperty
    a_tri_none: assert property (p_tri_none) else $error("no-link must be both high"); // RULE4

    property p_tri_ten;
        @(posedge pclk) disable iff (!presetn)
        !led.single_mode && led.link_up && led.speed == PPS_SPD_10 && !led.activity
            |=> !link_q && !act_q;
    endproperty
    a_tri_ten: assert property (p_tri_ten) else $error("10M needs both low"); // RULE5
endmodule : pps_led_enc

// ---- pps_led_if.sv ----
// Interface between core and indicator encoder
interface pps_led_if;
    import pps_pkg::*;
    logic single_mode;
    pps_speed_t speed;
    logic link_up;
    logic activity;
    logic blink;
    logic link_ind;
    logic act_ind;
    modport core (output single_mode, output speed, output link_up, output activity,
        output blink, input link_ind, input act_ind);
    modport enc (input single_mode, input speed, input link_up, input activity,
        input blink, output link_ind, output act_ind);
endinterface : pps_led_if

// ---- pps_pin_strap.sv ----
// PHY pin functions, strap capture and APB control for pin behaviour
//
// Summary of operation
// RULE1 - Pair B: gig B/A, else RX/TX by MDI
// RULE2 - Pairs C/D swap by MDI-X in gig only
// RULE3 - Single LED: link low, activity toggles
// RULE4 - Tri-color encodes speed, toggles on activity
// RULE5 - Tri-color 10M uses both pins jointly
// RULE6 - Straps latched at reset release edge
// RULE7 - Reset input is active low
// RULE8 - Address bits from link, activity, rxclk pins
// RULE9 - Mode bits from RD3..RD0 pins
// RULE10 - Refclk enable from receive control pin
// RULE11 - Enabled refclk output runs 125 MHz
// RULE12 - Control bit 14 sets interrupt polarity
// RULE13 - Enabled status conditions drive interrupt
// RULE14 - Wake event drives chosen pin low
// RULE15 - Wake and interrupt always push-pull
// RULE16 - MAC drives transmit clock, control, data
// RULE17 - Device drives receive pins after reset
// RULE18 - Management data synchronous to MDC input
// RULE19 - Upper two address bits forced zero
// RULE20 - LED style strap: high single, low tri
// RULE21 - Straps held until next reset
module pps_pin_strap (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link state from PHY core
    input wire logic link_up,
    input wire pps_pkg::pps_speed_t link_speed,
    input wire logic mdix_sel,
    input wire logic rx_activity,
    input wire logic tx_activity,
    input wire logic wake_event,
    input wire logic [pps_pkg::PPS_EVT_W-1:0] irq_events,
    // Media pair roles
    output pps_pkg::pps_role_t media_pair_b_pos,
    output pps_pkg::pps_role_t media_pair_c_pos,
    output pps_pkg::pps_role_t media_pair_d_pos,
    // Shared strap/indicator pins
    input wire logic link_indicator_in,
    output logic link_indicator_out,
    output logic link_indicator_oe,
    input wire logic activity_indicator_in,
    output logic activity_indicator_out,
    output logic activity_indicator_oe,
    // RGMII receive pins, straps during reset
    input wire logic [3:0] rx_data_in,
    output logic [3:0] rx_data_out,
    input wire logic rx_ctl_in,
    output logic rx_ctl_out,
    input wire logic rx_clk_in,
    output logic rx_clk_out,
    output logic rx_oe,
    input wire logic [3:0] rx_data_core,
    input wire logic rx_ctl_core,
    input wire logic rx_clk_core,
    // RGMII transmit pins from the MAC
    input wire logic [3:0] tx_data_in,
    input wire logic tx_ctl_in,
    input wire logic tx_clk_in,
    output logic [3:0] tx_data_core,
    output logic tx_ctl_core,
    output logic tx_clk_core,
    // Reference clock / LED style strap
    input wire logic refclk_in,
    output logic refclk_out_pin,
    output logic refclk_oe,
    // Interrupt and wake
    output logic irq_wake_out,
    output logic wake_event_out_opt1_en,
    // Management
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdc_core,
    output logic mdio_core_in,
    input wire logic mdio_core_out,
    input wire logic mdio_core_oe,
    output logic mdio_out,
    output logic mdio_oe,
    // Latched straps
    output logic [4:0] phy_address_strap,
    output logic [3:0] op_mode_strap,
    output logic refclk_out_enable_strap,
    output logic indicator_style_strap
);
    import pps_pkg::*;

    pps_state_t state_q;
    logic [4:0] addr_q;
    logic [3:0] mode_q;
    logic clken_q;
    logic ledsty_q;
    logic [31:0] ctrl_q;
    logic [PPS_EVT_W-1:0] irq_en_q;
    logic [PPS_EVT_W-1:0] irq_stat_q;
    logic [PPS_BLINK_W-1:0] blink_cnt_q;
    logic blink_q;
    logic refclk_q;
    logic irq_active;
    logic irq_level;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic clr_stat;

    pps_led_if led ();

    // Strap capture runs one clock after release, pins still undriven then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin // RULE7
            state_q <= PPS_ST_RESET;
        end else begin
            case (state_q)
                PPS_ST_RESET: state_q <= PPS_ST_LATCH;
                PPS_ST_LATCH: state_q <= PPS_ST_RUN;
                PPS_ST_RUN: state_q <= PPS_ST_RUN;
                default: state_q <= PPS_ST_RESET;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 5'h00;
            mode_q <= 4'h0;
            clken_q <= 1'b0;
            ledsty_q <= 1'b0;
        end else if (state_q == PPS_ST_RESET) begin // RULE6 RULE21
            addr_q <= {2'h0, rx_clk_in, link_indicator_in, activity_indicator_in}; // RULE8 RULE19
            mode_q <= rx_data_in; // RULE9
            clken_q <= rx_ctl_in; // RULE10
            ledsty_q <= refclk_in; // RULE20
        end
    end

    assign phy_address_strap = addr_q;
    assign op_mode_strap = mode_q;
    assign refclk_out_enable_strap = clken_q;
    assign indicator_style_strap = ledsty_q;

    // Pins stay inputs until straps are taken
    logic running;
    assign running = (state_q == PPS_ST_RUN);

    // Media pair roles
    always_comb begin
        if (link_speed == PPS_SPD_1000) begin
            media_pair_b_pos = mdix_sel ? PPS_ROLE_BI_A : PPS_ROLE_BI_B; // RULE1
            media_pair_c_pos = mdix_sel ? PPS_ROLE_BI_D : PPS_ROLE_BI_C; // RULE2
            media_pair_d_pos = mdix_sel ? PPS_ROLE_BI_C : PPS_ROLE_BI_D; // RULE2
        end else begin
            media_pair_b_pos = mdix_sel ? PPS_ROLE_TX : PPS_ROLE_RX; // RULE1
            media_pair_c_pos = PPS_ROLE_IDLE; // RULE2
            media_pair_d_pos = PPS_ROLE_IDLE; // RULE2
        end
    end

    // Blink generator for activity toggling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b1;
        end else if (blink_cnt_q == PPS_BLINK_W'(PPS_BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    assign led.single_mode = ledsty_q;
    assign led.speed = link_speed;
    assign led.link_up = link_up;
    assign led.activity = rx_activity | tx_activity;
    assign led.blink = blink_q;

    pps_led_enc u_led_enc (
        .pclk(pclk),
        .presetn(presetn),
        .led(led)
    );

    // Wake option 1 overrides the activity indicator
    logic wake_opt2;
    assign wake_opt2 = ctrl_q[PPS_CTRL_WAKE_OPT_BIT];
    assign wake_event_out_opt1_en = ~wake_opt2;
    assign link_indicator_out = led.link_ind;
    assign link_indicator_oe = running;
    assign activity_indicator_out = (!wake_opt2 && wake_event) ? 1'b0 : led.act_ind; // RULE14
    assign activity_indicator_oe = running; // RULE15

    // Reference clock at half pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refclk_q <= 1'b0;
        end else begin
            refclk_q <= clken_q & running & ~refclk_q; // RULE11
        end
    end
    assign refclk_out_pin = refclk_q;
    assign refclk_oe = running & clken_q; // RULE11

    // Receive pins toward the MAC
    assign rx_oe = running; // RULE17
    assign rx_data_out = rx_data_core; // RULE17
    assign rx_ctl_out = rx_ctl_core;
    assign rx_clk_out = rx_clk_core;
    assign tx_data_core = tx_data_in; // RULE16
    assign tx_ctl_core = tx_ctl_in;
    assign tx_clk_core = tx_clk_in;

    // Management pins pass to the serial engine, clocked by MDC
    assign mdc_core = mdc; // RULE18
    assign mdio_core_in = mdio_in;
    assign mdio_out = mdio_core_out;
    assign mdio_oe = mdio_core_oe;

    // APB decode, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~pwrite;
    always_comb begin
        case (paddr)
            PPS_OFF_CTRL, PPS_OFF_STRAP, PPS_OFF_IRQ_EN,
            PPS_OFF_IRQ_STAT, PPS_OFF_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= PPS_CTRL_RST;
        end else if (wr_en && paddr == PPS_OFF_CTRL) begin
            ctrl_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= PPS_EVT_RST;
        end else if (wr_en && paddr == PPS_OFF_IRQ_EN) begin
            irq_en_q <= pwdata[PPS_EVT_W-1:0];
        end
    end

    // Status clears on read; a new event in the same cycle wins
    assign clr_stat = psel & penable & ~pwrite & (paddr == PPS_OFF_IRQ_STAT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= PPS_EVT_RST;
        end else begin
            irq_stat_q <= (clr_stat ? PPS_EVT_RST : irq_stat_q) | irq_events; // RULE13
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            case (paddr)
                PPS_OFF_CTRL: prdata <= ctrl_q;
                PPS_OFF_STRAP: prdata <= {18'h0, ledsty_q, clken_q, mode_q, 3'h0, addr_q};
                PPS_OFF_IRQ_EN: prdata <= {24'h0, irq_en_q};
                PPS_OFF_IRQ_STAT: prdata <= {24'h0, irq_stat_q | irq_events}; // RULE13
                PPS_OFF_STATUS: prdata <= {27'h0, wake_event, irq_active, link_up, link_speed};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Interrupt pin, push-pull in both levels
    assign irq_active = |(irq_stat_q & irq_en_q); // RULE13
    assign irq_level = ctrl_q[PPS_CTRL_IRQ_POL_BIT] ? irq_active : ~irq_active; // RULE12
    assign irq_wake_out = (wake_opt2 && wake_event) ? 1'b0 : irq_level; // RULE14 RULE15

    property p_strap_hold;
        @(posedge pclk) disable iff (!presetn)
        running |=> $stable(addr_q) && $stable(mode_q) && $stable(clken_q) && $stable(ledsty_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after latch"); // RULE21

    property p_addr_upper;
        @(posedge pclk) disable iff (!presetn)
        addr_q[4:3] == 2'h0;
    endproperty
    a_addr_upper: assert property (p_addr_upper) else $error("upper address not zero"); // RULE19

    property p_strap_take;
        @(posedge pclk) disable iff (!presetn)
        state_q == PPS_ST_RESET |=> mode_q == $past(rx_data_in) && clken_q == $past(rx_ctl_in)
            && addr_q[2] == $past(rx_clk_in) && addr_q[1] == $past(link_indicator_in);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("strap not taken"); // RULE6 RULE8 RULE9

    property p_irq_pol;
        @(posedge pclk) disable iff (!presetn)
        !wake_event |-> irq_wake_out
            == (ctrl_q[PPS_CTRL_IRQ_POL_BIT] ~^ |(irq_stat_q & irq_en_q));
    endproperty
    a_irq_pol: assert property (p_irq_pol) else $error("interrupt polarity wrong"); // RULE12

    property p_stat_sticky;
        @(posedge pclk) disable iff (!presetn)
        |irq_events |=> (irq_stat_q & $past(irq_events)) == $past(irq_events);
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("event lost"); // RULE13

    property p_wake_low;
        @(posedge pclk) disable iff (!presetn)
        wake_event && running |-> (wake_opt2 ? !irq_wake_out : !activity_indicator_out);
    endproperty
    a_wake_low: assert property (p_wake_low) else $error("wake pin not low"); // RULE14

    property p_pair_gig;
        @(posedge pclk) disable iff (!presetn)
        link_speed == PPS_SPD_1000 && mdix_sel |-> media_pair_b_pos == PPS_ROLE_BI_A
            && media_pair_c_pos == PPS_ROLE_BI_D;
    endproperty
    a_pair_gig: assert property (p_pair_gig) else $error("pair map wrong"); // RULE1 RULE2

    property p_refclk;
        @(posedge pclk) disable iff (!presetn)
        running && clken_q && $past(running) |=> refclk_q != $past(refclk_q);
    endproperty
    a_refclk: assert property (p_refclk) else $error("refclk not toggling"); // RULE11

    property p_oe_drive;
        @(posedge pclk) disable iff (!presetn)
        running |-> activity_indicator_oe && rx_oe;
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("pins not driven"); // RULE15 RULE17
endmodule : pps_pin_strap

// ---- pps_pin_strap_bench.sv ----
// Self-checking bench for the pin function and strap block
module pps_pin_strap_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pps_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic link_up, mdix_sel, rx_activity, tx_activity, wake_event;
    pps_speed_t link_speed;
    logic [PPS_EVT_W-1:0] irq_events;
    pps_role_t media_pair_b_pos, media_pair_c_pos, media_pair_d_pos;
    logic link_indicator_in, link_indicator_out, link_indicator_oe;
    logic activity_indicator_in, activity_indicator_out, activity_indicator_oe;
    logic [3:0] rx_data_in, rx_data_out, rx_data_core, tx_data_in, tx_data_core;
    logic rx_ctl_in, rx_ctl_out, rx_clk_in, rx_clk_out, rx_oe, rx_ctl_core, rx_clk_core;
    logic tx_ctl_in, tx_clk_in, tx_ctl_core, tx_clk_core;
    logic refclk_in, refclk_out_pin, refclk_oe, irq_wake_out, wake_event_out_opt1_en;
    logic mdc, mdio_in, mdc_core, mdio_core_in, mdio_core_out, mdio_core_oe, mdio_out, mdio_oe;
    logic [4:0] phy_address_strap;
    logic [3:0] op_mode_strap;
    logic refclk_out_enable_strap, indicator_style_strap;
    logic [8:0] pulls;
    int num_errors = 0;
    int total_checks = 0;

    // Every port has a bench net of the same name
    pps_pin_strap dut (.*);

    pps_far_side far (.*);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic summarize;
        $display("Checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang;
        num_errors++;
        $display("ERROR wait expected done seen timeout");
        summarize();
    endtask

    // Bounded wait on pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_wake_out !== lvl && n < 8) begin
            @(negedge pclk);
            n++;
        end
        if (irq_wake_out !== lvl) hang();
        chk1("irq pin", lvl, irq_wake_out);
    endtask

    task automatic pulse(input logic [7:0] ev);
        @(posedge pclk);
        irq_events <= ev;
        @(posedge pclk);
        irq_events <= 8'h00;
    endtask

    task automatic t_strap(input logic [8:0] p);
        logic [31:0] exp;
        exp = {18'h0, p[8:7], p[6:3], 5'h00, p[2:0]};
        @(posedge pclk);
        pulls <= p;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        settle(3);
        chk("addr strap", {29'h0, p[2:0]}, {27'h0, phy_address_strap});
        chk("mode strap", {28'h0, p[6:3]}, {28'h0, op_mode_strap});
        chk1("clken strap", p[7], refclk_out_enable_strap);
        chk1("style strap", p[8], indicator_style_strap);
        apb(1'b0, PPS_OFF_CTRL, 32'h0000_0000);
        chk("ctrl reset", PPS_CTRL_RST, rd);
        apb(1'b1, PPS_OFF_STRAP, 32'hffff_ffff);
        apb(1'b0, PPS_OFF_STRAP, 32'h0000_0000);
        chk("strap reg", exp, rd);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk1("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0000_0000, rd);
        pulls <= ~p;
        apb(1'b0, PPS_OFF_STRAP, 32'h0000_0000);
        chk("strap hold", exp, rd);
        $display("test strap done");
    endtask

    task automatic t_pairs;
        pps_speed_t sp[3] = '{PPS_SPD_10, PPS_SPD_100, PPS_SPD_1000};
        logic g, x;
        for (int i = 0; i < 6; i++) begin
            @(posedge pclk);
            link_up <= 1'b1;
            link_speed <= sp[i/2];
            mdix_sel <= i[0];
            settle(0);
            g = sp[i/2] == PPS_SPD_1000;
            x = i[0];
            chk("pair b", 32'(g ? (x ? PPS_ROLE_BI_A : PPS_ROLE_BI_B)
                : (x ? PPS_ROLE_TX : PPS_ROLE_RX)), 32'(media_pair_b_pos));
            chk("pair c", 32'(g ? (x ? PPS_ROLE_BI_D : PPS_ROLE_BI_C) : PPS_ROLE_IDLE),
                32'(media_pair_c_pos));
            chk("pair d", 32'(g ? (x ? PPS_ROLE_BI_C : PPS_ROLE_BI_D) : PPS_ROLE_IDLE),
                32'(media_pair_d_pos));
        end
        $display("test pairs done");
    endtask

    task automatic t_pins;
        for (int j = 0; j < 2; j++) begin
            @(posedge pclk);
            rx_data_core <= j[0] ? 4'h6 : 4'h9;
            rx_ctl_core <= ~j[0];
            rx_clk_core <= j[0];
            mdio_core_out <= j[0];
            mdio_core_oe <= ~j[0];
            settle(0);
            chk1("rx oe", 1'b1, rx_oe);
            chk("rx pins", j[0] ? 32'h0000_0026 : 32'h0000_0019,
                {26'h0, rx_clk_out, rx_ctl_out, rx_data_out});
            chk("tx pins", {26'h0, tx_clk_in, tx_ctl_in, tx_data_in},
                {26'h0, tx_clk_core, tx_ctl_core, tx_data_core});
            chk1("mdc", mdc, mdc_core);
            chk1("mdio oe", ~j[0], mdio_oe);
            chk1("mdio in", j[0], mdio_core_in);
        end
        chk1("refclk oe", 1'b1, refclk_oe);
        err = refclk_out_pin;
        settle(0);
        chk1("refclk half", ~err, refclk_out_pin);
        settle(0);
        chk1("refclk full", err, refclk_out_pin);
        $display("test pins done");
    endtask

    task automatic t_irq;
        apb(1'b1, PPS_OFF_IRQ_EN, 32'h0000_0004);
        pulse(8'h08);
        settle(3);
        chk1("masked irq", 1'b1, irq_wake_out);
        apb(1'b0, PPS_OFF_IRQ_STAT, 32'h0000_0000);
        pulse(8'h04);
        wait_irq(1'b0);
        apb(1'b0, PPS_OFF_IRQ_STAT, 32'h0000_0000);
        chk("irq status", 32'h0000_0004, rd);
        wait_irq(1'b1);
        apb(1'b1, PPS_OFF_CTRL, 32'h0000_4000);
        wait_irq(1'b0);
        pulse(8'h04);
        wait_irq(1'b1);
        apb(1'b0, PPS_OFF_IRQ_STAT, 32'h0000_0000);
        apb(1'b1, PPS_OFF_CTRL, 32'h0000_0000);
        wait_irq(1'b1);
        $display("test irq done");
    endtask

    task automatic t_wake;
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, PPS_OFF_CTRL, {31'h0, j[0]});
            @(posedge pclk);
            wake_event <= 1'b1;
            settle(2);
            chk1("opt1 select", ~j[0], wake_event_out_opt1_en);
            chk1("wake opt1", j[0], activity_indicator_out);
            chk1("wake opt2", ~j[0], irq_wake_out);
            @(posedge pclk);
            wake_event <= 1'b0;
        end
        apb(1'b1, PPS_OFF_CTRL, 32'h0000_0000);
        $display("test wake done");
    endtask

    task automatic t_single;
        int n;
        @(posedge pclk);
        link_up <= 1'b0;
        settle(2);
        chk1("link off", 1'b1, link_indicator_out);
        chk1("act idle", 1'b1, activity_indicator_out);
        @(posedge pclk);
        link_up <= 1'b1;
        link_speed <= PPS_SPD_100;
        rx_activity <= 1'b1;
        settle(2);
        chk1("link on", 1'b0, link_indicator_out);
        n = 0;
        while (activity_indicator_out !== 1'b0 && n < 26000) begin
            @(negedge pclk);
            n++;
        end
        if (activity_indicator_out !== 1'b0) hang();
        @(posedge pclk);
        rx_activity <= 1'b0;
        settle(2);
        chk1("act rest", 1'b1, activity_indicator_out);
        $display("test single done");
    endtask

    task automatic t_tri;
        pps_speed_t sp[4] = '{PPS_SPD_NONE, PPS_SPD_1000, PPS_SPD_100, PPS_SPD_10};
        logic [1:0] ex[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            link_up <= i != 0;
            link_speed <= sp[i];
            settle(2);
            chk("tri pins", {30'h0, ex[i]},
                {30'h0, link_indicator_out, activity_indicator_out});
        end
        apb(1'b0, PPS_OFF_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0005, rd);
        $display("test tri done");
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        hang();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, link_up, mdix_sel} = '0;
        {rx_activity, tx_activity, wake_event, irq_events, rx_data_core} = '0;
        {rx_ctl_core, rx_clk_core, mdio_core_out, mdio_core_oe, pulls} = '0;
        link_speed = PPS_SPD_NONE;
        t_strap(9'h1d5);
        t_pairs();
        t_pins();
        t_irq();
        t_wake();
        t_single();
        t_strap(9'h02a);
        t_tri();
        summarize();
    end
endmodule // pps_pin_strap_bench

// ---- pps_pkg.sv ----
// Package for the PHY pin function and strap logic
package pps_pkg;
    // Speed codes
    typedef enum logic [1:0] {
        PPS_SPD_NONE = 2'h0,
        PPS_SPD_10   = 2'h1,
        PPS_SPD_100  = 2'h3,
        PPS_SPD_1000 = 2'h2
    } pps_speed_t;

    // Media pair roles
    typedef enum logic [2:0] {
        PPS_ROLE_IDLE = 3'h0,
        PPS_ROLE_BI_A = 3'h1,
        PPS_ROLE_BI_B = 3'h2,
        PPS_ROLE_BI_C = 3'h3,
        PPS_ROLE_BI_D = 3'h4,
        PPS_ROLE_TX   = 3'h5,
        PPS_ROLE_RX   = 3'h6
    } pps_role_t;

    // Strap capture state
    typedef enum logic [1:0] {
        PPS_ST_RESET = 2'h0,
        PPS_ST_LATCH = 2'h1,
        PPS_ST_RUN   = 2'h3
    } pps_state_t;

    // APB register byte offsets
    localparam logic [7:0] PPS_OFF_CTRL = 8'h00;
    localparam logic [7:0] PPS_OFF_STRAP = 8'h04;
    localparam logic [7:0] PPS_OFF_IRQ_EN = 8'h08;
    localparam logic [7:0] PPS_OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] PPS_OFF_STATUS = 8'h10;

    // Control register fields
    localparam int PPS_CTRL_IRQ_POL_BIT = 14;
    localparam int PPS_CTRL_WAKE_OPT_BIT = 0;
    localparam logic [31:0] PPS_CTRL_RST = 32'h0000_0000;

    // Strap register fields
    localparam int PPS_STRAP_ADDR_LSB = 0;
    localparam int PPS_STRAP_MODE_LSB = 8;
    localparam int PPS_STRAP_CLKEN_BIT = 12;
    localparam int PPS_STRAP_LEDSTY_BIT = 13;

    localparam int PPS_EVT_W = 8;
    localparam logic [PPS_EVT_W-1:0] PPS_EVT_RST = 8'h00;

    // Blink timing
    localparam int PPS_CLK_MHZ = 250;
    localparam int PPS_BLINK_US = 100;
    localparam int PPS_BLINK_CYC = PPS_BLINK_US * PPS_CLK_MHZ;
    localparam int PPS_BLINK_W = 15;
    // Reference clock: 125 MHz is half of pclk
    localparam int PPS_REFCLK_DIV = 2;
endpackage : pps_pkg
